// [include/uoob_defs.svh]
`ifndef UOOB_DEFS_SVH
`define UOOB_DEFS_SVH

// Line group geometry
`define UOOB_LINES 16
`define UOOB_SEL_W 4
`define UOOB_HOLD_W 16
`define UOOB_PRE_W 15

// Clock and wake hold time unit
`define UOOB_CLK_HZ 25000000
`define UOOB_HOLD_UNIT_MS 1
`define UOOB_HOLD_UNIT_CYCLES ((`UOOB_CLK_HZ / 1000) * `UOOB_HOLD_UNIT_MS)

// Controller register offsets
`define UOOB_ADDR_W 8
`define UOOB_REG_CTRL 8'h00
`define UOOB_REG_SEL 8'h04
`define UOOB_REG_STATUS 8'h08
`define UOOB_REG_MASK 8'h0c
`define UOOB_REG_LEVEL 8'h10

// Field positions
`define UOOB_CTRL_DETACH 0
`define UOOB_SEL_RESUME_LSB 0
`define UOOB_SEL_DETACH_LSB 4
`define UOOB_SEL_WAKE_LSB 8
`define UOOB_EV_RESUME_RISE 0
`define UOOB_EV_WAKE_RISE 1
`define UOOB_EV_WAKE_FALL 2
`define UOOB_EV_W 3

// Reset values
`define UOOB_SEL_RST 12'h210
`define UOOB_MASK_RST 3'h0

`endif

// [include/uoob_pkg.sv]
`include "uoob_defs.svh"

package uoob_pkg;

   typedef enum logic [1:0] {
      UOOB_ATTACHED = 2'b01,
      UOOB_DETACHED = 2'b10
   } uoob_mode_t;

   typedef struct packed {
      uoob_mode_t mode;
      logic [2:0] det_sync;
      logic det_lvl;
      logic resume_req;
      logic wake;
      logic wake_forever;
      logic [`UOOB_PRE_W-1:0] prescale;
      logic [`UOOB_HOLD_W-1:0] hold_left;
      logic [`UOOB_LINES-1:0] line;
   } uoob_dev_st_t;

   typedef struct packed {
      logic detach_req;
      logic [11:0] sel;
      logic [`UOOB_EV_W-1:0] status;
      logic [`UOOB_EV_W-1:0] mask;
      logic [2:0] res_sync;
      logic [2:0] wake_sync;
      logic res_lvl;
      logic wake_lvl;
      logic [`UOOB_LINES-1:0] line;
      logic [31:0] rd_data;
   } uoob_host_st_t;

endpackage

// [include/uoob_if.sv]
`include "uoob_defs.svh"

interface uoob_if;
   logic [`UOOB_LINES-1:0] dev_line;
   logic [`UOOB_LINES-1:0] host_line;

   modport dev (output dev_line, input host_line);
   modport host (input dev_line, output host_line);
endinterface

// [design/uoob_dev.sv]
// Summary of operation
// - Resume, detach, wake each on own line
// - Resume line high until bus activity returns
// - Resume enabled by line selection alone
// - No resume line selected: function unused
// - Host takes resume line as interrupt
// - Suspend keeps pull-up powered, stays attached
// - Detach floats D+/D-, removes pull-up power
// - Radio continues; host traffic triggers wake
// - USB restarts after host drops detach or the detach line is disabled
// - Hold time zero keeps wake until reattach
// - No hold time configured: wake held indefinitely
// - Resume in suspend and detach; wake detach only
// - Host processes stale queued events after reconnect
`include "uoob_defs.svh"

module uoob_dev
   import uoob_pkg::*;
#(
   parameter int HOLD_UNIT_CYCLES = `UOOB_HOLD_UNIT_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   uoob_if.dev link,
   input wire logic resume_line_en_in,
   input wire logic [`UOOB_SEL_W-1:0] resume_line_select_in,
   input wire logic detach_line_en_in,
   input wire logic [`UOOB_SEL_W-1:0] detach_line_select_in,
   input wire logic wake_line_en_in,
   input wire logic [`UOOB_SEL_W-1:0] wake_line_select_in,
   input wire logic wake_hold_present_in,
   input wire logic [`UOOB_HOLD_W-1:0] wake_hold_time_in,
   input wire logic suspended_in,
   input wire logic bus_activity_in,
   input wire logic resume_want_in,
   input wire logic traffic_event_in,
   input wire logic usb_oe_n_in,
   output logic dp_oe_n_out,
   output logic dm_oe_n_out,
   output logic pullup_power_out,
   output logic usb_enable_out,
   output logic detached_out,
   output logic resume_active_out,
   output logic wake_active_out
);

   localparam logic [`UOOB_PRE_W-1:0] PRE_LAST = `UOOB_PRE_W'(HOLD_UNIT_CYCLES - 1);

   uoob_dev_st_t st;
   uoob_dev_st_t next_st;
   logic det_pin;
   logic det_on;
   logic in_detach;
   logic unit_tick;
   logic [`UOOB_LINES-1:0] next_line;

   // Detach pin taken from its selected line
   assign det_pin = link.host_line[detach_line_select_in];
   assign det_on = detach_line_en_in && st.det_lvl;
   assign in_detach = (st.mode == UOOB_DETACHED);
   assign unit_tick = (st.prescale == PRE_LAST);

   // Resume and wake each drive their own line
   genvar i;
   generate
      for (i = 0; i < `UOOB_LINES; i++) begin : g_line
         assign next_line[i] =
            (resume_line_en_in && (resume_line_select_in == `UOOB_SEL_W'(i)) && st.resume_req) |
            (wake_line_en_in && (wake_line_select_in == `UOOB_SEL_W'(i)) && st.wake);
      end
   endgenerate

   always_comb begin
      next_st = st;

      // Three-stage sampler, level taken when stages two and three agree
      next_st.det_sync = {st.det_sync[1:0], det_pin};
      if (st.det_sync[1] == st.det_sync[2]) begin
         next_st.det_lvl = st.det_sync[2];
      end

      // Attach state follows the filtered detach level
      case (st.mode)
         UOOB_ATTACHED: begin
            if (det_on) begin
               next_st.mode = UOOB_DETACHED;
            end
         end
         UOOB_DETACHED: begin
            if (!det_on) begin
               next_st.mode = UOOB_ATTACHED;
            end
         end
         default: begin
            next_st.mode = UOOB_ATTACHED;
         end
      endcase

      // Resume request, needs only a selected line
      if (!resume_line_en_in) begin
         next_st.resume_req = 1'b0;
      end else if (resume_want_in && (suspended_in || in_detach)) begin
         next_st.resume_req = 1'b1;
      end else if (bus_activity_in) begin
         next_st.resume_req = 1'b0;
      end

      // Wake hold timing, detach mode only
      if (!wake_line_en_in || !in_detach) begin
         next_st.wake = 1'b0;
         next_st.wake_forever = 1'b0;
         next_st.hold_left = '0;
         next_st.prescale = '0;
      end else if (traffic_event_in) begin
         next_st.wake = 1'b1;
         next_st.hold_left = wake_hold_time_in;
         next_st.prescale = '0;
         next_st.wake_forever = !wake_hold_present_in ||
                                (wake_hold_time_in == '0);
      end else if (st.wake && !st.wake_forever) begin
         if (unit_tick) begin
            next_st.prescale = '0;
            next_st.hold_left = st.hold_left - `UOOB_HOLD_W'(1);
            if (st.hold_left == `UOOB_HOLD_W'(1)) begin
               next_st.wake = 1'b0;
            end
         end else begin
            next_st.prescale = st.prescale + `UOOB_PRE_W'(1);
         end
      end

      next_st.line = next_line;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st.mode <= UOOB_ATTACHED;
         st.det_sync <= 3'h0;
         st.det_lvl <= 1'b0;
         st.resume_req <= 1'b0;
         st.wake <= 1'b0;
         st.wake_forever <= 1'b0;
         st.prescale <= '0;
         st.hold_left <= '0;
         st.line <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign link.dev_line = st.line;

   // Pull-up stays powered in suspend; only detach removes it
   assign pullup_power_out = (st.mode == UOOB_ATTACHED);
   assign dp_oe_n_out = usb_oe_n_in || in_detach;
   assign dm_oe_n_out = usb_oe_n_in || in_detach;
   assign usb_enable_out = (st.mode == UOOB_ATTACHED);
   assign detached_out = in_detach;
   assign resume_active_out = st.resume_req;
   assign wake_active_out = st.wake;

endmodule

// [design/uoob_host.sv]
`include "uoob_defs.svh"

module uoob_host
   import uoob_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   uoob_if.host link,
   input wire logic [`UOOB_ADDR_W-1:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rd_data_out,
   output logic irq_out,
   output logic port_wake_out
);

   uoob_host_st_t st;
   uoob_host_st_t next_st;
   logic [`UOOB_SEL_W-1:0] res_sel;
   logic [`UOOB_SEL_W-1:0] det_sel;
   logic [`UOOB_SEL_W-1:0] wake_sel;
   logic [`UOOB_EV_W-1:0] events;
   logic [`UOOB_EV_W-1:0] clr;
   logic [`UOOB_LINES-1:0] next_line;

   assign res_sel = st.sel[`UOOB_SEL_RESUME_LSB +: `UOOB_SEL_W];
   assign det_sel = st.sel[`UOOB_SEL_DETACH_LSB +: `UOOB_SEL_W];
   assign wake_sel = st.sel[`UOOB_SEL_WAKE_LSB +: `UOOB_SEL_W];

   // Detach driven only on its selected line, by software alone
   genvar i;
   generate
      for (i = 0; i < `UOOB_LINES; i++) begin : g_line
         assign next_line[i] = st.detach_req && (det_sel == `UOOB_SEL_W'(i));
      end
   endgenerate

   always_comb begin
      next_st = st;
      events = '0;
      clr = '0;

      // Three-stage samplers on the device lines
      next_st.res_sync = {st.res_sync[1:0], link.dev_line[res_sel]};
      next_st.wake_sync = {st.wake_sync[1:0], link.dev_line[wake_sel]};
      if (st.res_sync[1] == st.res_sync[2]) begin
         next_st.res_lvl = st.res_sync[2];
      end
      if (st.wake_sync[1] == st.wake_sync[2]) begin
         next_st.wake_lvl = st.wake_sync[2];
      end

      // Resume rise, with its mask bit set, raises an interrupt and wakes the port
      events[`UOOB_EV_RESUME_RISE] = next_st.res_lvl && !st.res_lvl;
      events[`UOOB_EV_WAKE_RISE] = next_st.wake_lvl && !st.wake_lvl;
      events[`UOOB_EV_WAKE_FALL] = !next_st.wake_lvl && st.wake_lvl;

      if (wr_in) begin
         case (addr_in)
            `UOOB_REG_CTRL: next_st.detach_req = wr_data_in[`UOOB_CTRL_DETACH];
            `UOOB_REG_SEL: next_st.sel = wr_data_in[11:0];
            `UOOB_REG_STATUS: clr = wr_data_in[`UOOB_EV_W-1:0];
            `UOOB_REG_MASK: next_st.mask = wr_data_in[`UOOB_EV_W-1:0];
            default: begin
            end
         endcase
      end
      // Set wins over a simultaneous clear
      next_st.status = (st.status & ~clr) | events;

      next_st.rd_data = 32'h0;
      if (rd_in) begin
         case (addr_in)
            `UOOB_REG_CTRL: next_st.rd_data = {31'h0, st.detach_req};
            `UOOB_REG_SEL: next_st.rd_data = {20'h0, st.sel};
            `UOOB_REG_STATUS: next_st.rd_data = {29'h0, st.status};
            `UOOB_REG_MASK: next_st.rd_data = {29'h0, st.mask};
            `UOOB_REG_LEVEL: next_st.rd_data = {29'h0, st.detach_req, st.wake_lvl, st.res_lvl};
            default: next_st.rd_data = 32'h0;
         endcase
      end

      next_st.line = next_line;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st.detach_req <= 1'b0;
         st.sel <= `UOOB_SEL_RST;
         st.status <= '0;
         st.mask <= `UOOB_MASK_RST;
         st.res_sync <= 3'h0;
         st.wake_sync <= 3'h0;
         st.res_lvl <= 1'b0;
         st.wake_lvl <= 1'b0;
         st.line <= '0;
         st.rd_data <= 32'h0;
      end else begin
         st <= next_st;
      end
   end

   assign link.host_line = st.line;
   assign rd_data_out = st.rd_data;
   assign irq_out = |(st.status & st.mask);
   assign port_wake_out = st.status[`UOOB_EV_RESUME_RISE] && st.mask[`UOOB_EV_RESUME_RISE];

endmodule

// [bench/uoob_properties.sv]
`include "uoob_defs.svh"

module uoob_properties (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [`UOOB_LINES-1:0] dev_line,
   input wire logic [`UOOB_LINES-1:0] host_line,
   input wire logic detach_line_en_in,
   input wire logic resume_line_en_in,
   input wire logic wake_line_en_in,
   input wire logic bus_activity_in,
   input wire logic detached_out,
   input wire logic usb_enable_out,
   input wire logic pullup_power_out,
   input wire logic dp_oe_n_out,
   input wire logic dm_oe_n_out,
   input wire logic resume_active_out,
   input wire logic wake_active_out
);
   // Lines: 0 resume, 1 detach, 2 wake
   default clocking dc @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   chk_float_detach: assert property (detached_out |-> dp_oe_n_out && dm_oe_n_out)
      else $error("data lines driven while detached");
   chk_pullup_state: assert property (pullup_power_out == !detached_out)
      else $error("pull-up power wrong");
   chk_usb_held: assert property (detached_out |-> !usb_enable_out)
      else $error("usb enabled while detached");
   chk_detach_entry: assert property ($rose(host_line[1]) && detach_line_en_in ##1
      (host_line[1] && detach_line_en_in)[*3] |=> ##1 detached_out)
      else $error("detach not entered on time");
   chk_detach_exit: assert property ($fell(host_line[1]) ##1
      (!host_line[1])[*3] |=> ##1 !detached_out)
      else $error("detach not left on time");
   chk_detach_refused: assert property ((!detach_line_en_in)[*3] |-> !detached_out)
      else $error("detached while detach unused");
   chk_resume_line: assert property (resume_line_en_in && $past(resume_line_en_in) |->
      dev_line[0] == $past(resume_active_out))
      else $error("resume line mismatch");
   chk_resume_holds: assert property (
      resume_active_out && !bus_activity_in && resume_line_en_in |=> resume_active_out)
      else $error("resume dropped early");
   chk_wake_line: assert property (wake_line_en_in && $past(wake_line_en_in) |->
      dev_line[2] == $past(wake_active_out))
      else $error("wake line mismatch");
   chk_wake_detach_only: assert property (
      wake_active_out |-> detached_out || $past(detached_out))
      else $error("wake outside detach");
   chk_wake_hold: assert property ($rose(wake_active_out) |-> wake_active_out[*8])
      else $error("wake hold too short");

   cov_detach: cover property ($rose(detached_out));
   cov_wake: cover property ($rose(wake_active_out));
   cov_resume: cover property ($rose(dev_line[0]));
endmodule

// [bench/uoob_bench.sv]
`include "uoob_defs.svh"

module uoob_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic [31:0] v;} uoob_row_t;
   uoob_row_t rows [6] = '{'{8'h00, 32'h0}, '{8'h04, 32'h210}, '{8'h08, 32'h0},
      '{8'h0c, 32'h0}, '{8'h10, 32'h0}, '{8'h14, 32'h0}};
   logic ref_clk_in = 1'b0, rst_n_in = 1'b0, resume_line_en_in = 1'b1;
   logic detach_line_en_in = 1'b1, wake_line_en_in = 1'b1, wake_hold_present_in = 1'b1;
   logic suspended_in = 1'b0, bus_activity_in = 1'b0, resume_want_in = 1'b0;
   logic traffic_event_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, irq_out, port_wake_out;
   logic dp_oe_n_out, dm_oe_n_out, pullup_power_out, usb_enable_out, detached_out;
   logic resume_active_out, wake_active_out, usb_oe_n_in = 1'b0;
   logic [15:0] wake_hold_time_in = 16'h0002;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wr_data_in = 32'h0, rd_data_out;
   int fails = 0, tests_run = 0, cycles = 0;
   uoob_if link_if ();

   uoob_dev #(.HOLD_UNIT_CYCLES(4)) uoob_dev_inst (.ref_clk_in, .rst_n_in, .link(link_if),
      .resume_line_en_in, .resume_line_select_in(4'h0), .detach_line_en_in,
      .detach_line_select_in(4'h1), .wake_line_en_in, .wake_line_select_in(4'h2),
      .wake_hold_present_in, .wake_hold_time_in, .suspended_in, .bus_activity_in,
      .resume_want_in, .traffic_event_in, .usb_oe_n_in, .dp_oe_n_out, .dm_oe_n_out,
      .pullup_power_out, .usb_enable_out, .detached_out, .resume_active_out, .wake_active_out);
   uoob_host uoob_host_inst (.ref_clk_in, .rst_n_in, .link(link_if), .addr_in, .wr_data_in,
      .wr_in, .rd_in, .rd_data_out, .irq_out, .port_wake_out);
   uoob_properties uoob_properties_inst (.ref_clk_in, .rst_n_in, .dev_line(link_if.dev_line),
      .host_line(link_if.host_line), .detach_line_en_in, .resume_line_en_in, .wake_line_en_in,
      .bus_activity_in, .detached_out, .usb_enable_out, .pullup_power_out, .dp_oe_n_out,
      .dm_oe_n_out, .resume_active_out, .wake_active_out);

   always #20 ref_clk_in = ~ref_clk_in;

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bit_chk(input logic got, input logic exp);
      check({31'h0, got}, {31'h0, exp});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 check(rd_data_out, exp);
   endtask

   // One-cycle traffic or resume request
   task automatic pulse(input logic t);
      @(posedge ref_clk_in);
      if (t) traffic_event_in <= 1'b1;
      else resume_want_in <= 1'b1;
      @(posedge ref_clk_in);
      traffic_event_in <= 1'b0;
      resume_want_in <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask

   initial begin
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      foreach (rows[i]) rd_chk(rows[i].a, rows[i].v);
      wr(8'h0c, 32'h7);
      wr(8'h10, 32'h7);
      rd_chk(8'h0c, 32'h7);
      rd_chk(8'h10, 32'h0);
      pulse(1'b0);
      idle(8);
      bit_chk(link_if.dev_line[0], 1'b0);
      @(posedge ref_clk_in);
      suspended_in <= 1'b1;
      resume_line_en_in <= 1'b0;
      pulse(1'b0);
      idle(8);
      bit_chk(link_if.dev_line[0], 1'b0);
      @(posedge ref_clk_in);
      resume_line_en_in <= 1'b1;
      pulse(1'b0);
      idle(8);
      bit_chk(link_if.dev_line[0], 1'b1);
      bit_chk(irq_out, 1'b1);
      bit_chk(port_wake_out, 1'b1);
      bit_chk(pullup_power_out, 1'b1);
      rd_chk(8'h08, 32'h1);
      wr(8'h08, 32'h1);
      idle(2);
      bit_chk(irq_out, 1'b0);
      idle(20);
      bit_chk(link_if.dev_line[0], 1'b1);
      @(posedge ref_clk_in);
      bus_activity_in <= 1'b1;
      suspended_in <= 1'b0;
      @(posedge ref_clk_in);
      bus_activity_in <= 1'b0;
      idle(8);
      bit_chk(link_if.dev_line[0], 1'b0);
      @(posedge ref_clk_in);
      detach_line_en_in <= 1'b0;
      wr(8'h00, 32'h1);
      idle(8);
      bit_chk(detached_out, 1'b0);
      @(posedge ref_clk_in);
      detach_line_en_in <= 1'b1;
      idle(8);
      bit_chk(pullup_power_out, 1'b0);
      bit_chk(dp_oe_n_out, 1'b1);
      bit_chk(dm_oe_n_out, 1'b1);
      bit_chk(usb_enable_out, 1'b0);
      pulse(1'b0);
      pulse(1'b1);
      idle(3);
      pulse(1'b1);
      idle(7);
      bit_chk(wake_active_out, 1'b1);
      idle(1);
      bit_chk(wake_active_out, 1'b0);
      idle(8);
      bit_chk(link_if.dev_line[0], 1'b1);
      rd_chk(8'h08, 32'h7);
      wr(8'h00, 32'h0);
      idle(8);
      bit_chk(usb_enable_out, 1'b1);
      bit_chk(dp_oe_n_out, 1'b0);
      bit_chk(dm_oe_n_out, 1'b0);
      @(posedge ref_clk_in);
      usb_oe_n_in <= 1'b1;
      idle(1);
      bit_chk(dm_oe_n_out, 1'b1);
      @(posedge ref_clk_in);
      usb_oe_n_in <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk_in);
         wake_hold_present_in <= k[0];
         wake_hold_time_in <= 16'h0000;
         wr(8'h00, 32'h1);
         idle(8);
         pulse(1'b1);
         idle(40);
         bit_chk(wake_active_out, 1'b1);
         wr(8'h00, 32'h0);
         idle(8);
         bit_chk(wake_active_out, 1'b0);
      end
      pulse(1'b1);
      idle(4);
      bit_chk(wake_active_out, 1'b0);
      wr(8'h00, 32'h1);
      idle(8);
      @(posedge ref_clk_in);
      rst_n_in <= 1'b0;
      idle(2);
      bit_chk(pullup_power_out, 1'b1);
      @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      rd_chk(8'h00, 32'h0);
      stop_test();
   end
endmodule
